// ### fcp_pkg.sv
package fcp_pkg;

   localparam int NUM_CHAN      = 4;
   localparam int PRESCALE_TAPS = 11;
   localparam int NUM_CLOCKS    = 13;
   localparam int CNT_W         = 16;
   localparam int DIV_W         = 8;
   localparam int SEL_W         = 4;
   localparam int DATA_W        = 32;
   localparam int CHAN_IDX_W    = 2;

   // Clock select codes: the top prescaler tap and the two divider clocks above it
   localparam logic [SEL_W-1:0] SEL_PRE_MAX = 4'hA;
   localparam logic [SEL_W-1:0] SEL_CLK_A   = 4'hB;
   localparam logic [SEL_W-1:0] SEL_CLK_B   = 4'hC;

   // Clock generator mode word layout
   localparam int MR_DIVIDER_A_FACTOR_LSB = 0;
   localparam int MR_PRESCALE_A_SELECT_LSB = 8;
   localparam int MR_DIVIDER_B_FACTOR_LSB = 16;
   localparam int MR_PRESCALE_B_SELECT_LSB = 24;

   // Channel mode word layout
   localparam int CMR_SEL_LSB   = 0;
   localparam int CMR_ALIGN_BIT = 8;
   localparam int CMR_POL_BIT   = 9;
   localparam int CMR_UPD_BIT   = 10;

   typedef enum logic [3:0] {
      WR_NONE,
      WR_CLOCKGEN_MODE,
      WR_CHAN_MODE,
      WR_CHAN_PERIOD,
      WR_CHAN_DUTY,
      WR_CHAN_UPDATE,
      WR_CHAN_ENABLE,
      WR_CHAN_DISABLE,
      WR_IRQ_ENABLE,
      WR_IRQ_DISABLE
   } fcp_wr_kind_e;

   typedef struct packed {
      fcp_wr_kind_e            kind;
      logic [CHAN_IDX_W-1:0]   chan;
      logic [DATA_W-1:0]       data;
   } fcp_wr_s;

   typedef struct packed {
      logic [SEL_W-1:0] prescale_b_select;
      logic [DIV_W-1:0] divider_b_factor;
      logic [SEL_W-1:0] prescale_a_select;
      logic [DIV_W-1:0] divider_a_factor;
   } fcp_clockgen_s;

   typedef struct packed {
      logic             update_target;
      logic             start_polarity;
      logic             center_align_select;
      logic [SEL_W-1:0] chan_clock_select;
   } fcp_chan_mode_s;

   localparam fcp_clockgen_s  CLOCKGEN_RST  = '0;
   localparam fcp_chan_mode_s CHAN_MODE_RST = '0;
   localparam logic [CNT_W-1:0] CNT_RST     = 16'h0000;

endpackage

// ### fcp_lin_div.sv
`timescale 1ns/100ps
`default_nettype none

module fcp_lin_div #(
   parameter int DIV_W = fcp_pkg::DIV_W
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_b_in,
   input  wire logic             tick_in,
   input  wire logic [DIV_W-1:0] factor_in,
   output logic                  tick_out
);

   logic [DIV_W-1:0] cnt;
   wire              stopped = (factor_in == '0);
   wire              wrap    = (cnt >= DIV_W'(factor_in - 1'b1));

   // Output pulse is registered: one master cycle of latency against the source
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt      <= '0;
         tick_out <= 1'b0;
      end else if (stopped) begin
         cnt      <= '0;
         tick_out <= 1'b0;
      end else if (tick_in) begin
         cnt      <= wrap ? '0 : DIV_W'(cnt + 1'b1);
         tick_out <= wrap;
      end else begin
         tick_out <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ### fcp_core.sv
`timescale 1ns/100ps
`default_nettype none

module fcp_core #(
   parameter int NUM_CHAN = fcp_pkg::NUM_CHAN,
   parameter int CNT_W    = fcp_pkg::CNT_W
) (
   input  wire logic                              mclk_in,
   input  wire logic                              rst_b_in,
   input  wire logic                              func_clk_en_in,
   input  wire fcp_pkg::fcp_wr_s                  reg_wr_in,
   input  wire logic                              irq_status_rd_in,
   output logic [NUM_CHAN-1:0]                    chan_wave_out,
   output logic [NUM_CHAN-1:0]                    chan_enabled_out,
   output logic [NUM_CHAN-1:0]                    irq_flags_out,
   output logic [NUM_CHAN-1:0]                    irq_mask_out,
   output logic                                   irq_out,
   output fcp_pkg::fcp_clockgen_s                 clockgen_mode_out,
   output logic [NUM_CHAN-1:0][CNT_W-1:0]         chan_count_out
);

   localparam int PRE_W = fcp_pkg::PRESCALE_TAPS - 1;

   function automatic logic pick_tick(
      input logic [fcp_pkg::SEL_W-1:0]      code,
      input logic [fcp_pkg::SEL_W-1:0]      limit,
      input logic [fcp_pkg::NUM_CLOCKS-1:0] ticks
   );
      pick_tick = (code <= limit) ? ticks[code] : 1'b0;
   endfunction

   // Write decode
   wire wr_clockgen = (reg_wr_in.kind == fcp_pkg::WR_CLOCKGEN_MODE);
   wire wr_mode     = (reg_wr_in.kind == fcp_pkg::WR_CHAN_MODE);
   wire wr_period   = (reg_wr_in.kind == fcp_pkg::WR_CHAN_PERIOD);
   wire wr_duty     = (reg_wr_in.kind == fcp_pkg::WR_CHAN_DUTY);
   wire wr_update   = (reg_wr_in.kind == fcp_pkg::WR_CHAN_UPDATE);
   wire wr_enable   = (reg_wr_in.kind == fcp_pkg::WR_CHAN_ENABLE);
   wire wr_disable  = (reg_wr_in.kind == fcp_pkg::WR_CHAN_DISABLE);
   wire wr_irq_en   = (reg_wr_in.kind == fcp_pkg::WR_IRQ_ENABLE);
   wire wr_irq_dis  = (reg_wr_in.kind == fcp_pkg::WR_IRQ_DISABLE);

   wire [NUM_CHAN-1:0] wr_bits = reg_wr_in.data[NUM_CHAN-1:0];
   wire [CNT_W-1:0]    wr_word = reg_wr_in.data[CNT_W-1:0];

   // Clock generator mode register, written regardless of the functional gate
   fcp_pkg::fcp_clockgen_s next_clockgen;
   assign next_clockgen.divider_a_factor  =
      reg_wr_in.data[fcp_pkg::MR_DIVIDER_A_FACTOR_LSB +: fcp_pkg::DIV_W];
   assign next_clockgen.prescale_a_select =
      reg_wr_in.data[fcp_pkg::MR_PRESCALE_A_SELECT_LSB +: fcp_pkg::SEL_W];
   assign next_clockgen.divider_b_factor  =
      reg_wr_in.data[fcp_pkg::MR_DIVIDER_B_FACTOR_LSB +: fcp_pkg::DIV_W];
   assign next_clockgen.prescale_b_select =
      reg_wr_in.data[fcp_pkg::MR_PRESCALE_B_SELECT_LSB +: fcp_pkg::SEL_W];

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         clockgen_mode_out <= fcp_pkg::CLOCKGEN_RST;
      end else if (wr_clockgen) begin
         clockgen_mode_out <= next_clockgen;
      end
   end

   // Prescaler: taps are enable pulses, all held off while the clock is gated
   logic [PRE_W-1:0]              pre_cnt;
   logic [fcp_pkg::NUM_CLOCKS-1:0] clk_tick;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pre_cnt <= '0;
      end else if (func_clk_en_in) begin
         pre_cnt <= PRE_W'(pre_cnt + 1'b1);
      end
   end

   assign clk_tick[0] = func_clk_en_in;
   generate
      for (genvar k = 1; k < fcp_pkg::PRESCALE_TAPS; k++) begin : g_tap
         assign clk_tick[k] = func_clk_en_in & (&pre_cnt[k-1:0]);
      end
   endgenerate

   // Linear dividers feed the two top clock codes
   wire div_a_src = pick_tick(clockgen_mode_out.prescale_a_select,
                              fcp_pkg::SEL_PRE_MAX, clk_tick);
   wire div_b_src = pick_tick(clockgen_mode_out.prescale_b_select,
                              fcp_pkg::SEL_PRE_MAX, clk_tick);

   fcp_lin_div #(.DIV_W(fcp_pkg::DIV_W)) u_div_a (
      .mclk_in   (mclk_in),
      .rst_b_in  (rst_b_in),
      .tick_in   (div_a_src),
      .factor_in (clockgen_mode_out.divider_a_factor),
      .tick_out  (clk_tick[fcp_pkg::SEL_CLK_A])
   );

   fcp_lin_div #(.DIV_W(fcp_pkg::DIV_W)) u_div_b (
      .mclk_in   (mclk_in),
      .rst_b_in  (rst_b_in),
      .tick_in   (div_b_src),
      .factor_in (clockgen_mode_out.divider_b_factor),
      .tick_out  (clk_tick[fcp_pkg::SEL_CLK_B])
   );

   logic [NUM_CHAN-1:0] period_end;

   // Channels
   generate
      for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
         localparam logic [fcp_pkg::CHAN_IDX_W-1:0] ID = fcp_pkg::CHAN_IDX_W'(i);

         fcp_pkg::fcp_chan_mode_s mode;
         fcp_pkg::fcp_chan_mode_s next_mode;
         logic [CNT_W-1:0]        cnt;
         logic [CNT_W-1:0]        period;
         logic [CNT_W-1:0]        duty;
         logic [CNT_W-1:0]        upd_val;
         logic                    dir_down;
         logic                    upd_pending;
         logic                    enabled;
         logic                    wave;

         wire sel      = (reg_wr_in.chan == ID);
         wire en_set   = wr_enable & wr_bits[i] & ~enabled;
         wire dis_set  = wr_disable & wr_bits[i];
         wire upd_wr   = wr_update & sel;
         wire tick     = enabled &
                         pick_tick(mode.chan_clock_select, fcp_pkg::SEL_CLK_B, clk_tick);

         wire [CNT_W:0] cnt_inc  = {1'b0, cnt} + 1'b1;
         wire           up_top   = (cnt_inc >= {1'b0, period});
         wire           at_floor = (cnt <= CNT_W'(1'b1));
         wire           center   = mode.center_align_select;
         // Left wraps after period steps; centre turns at period, ends at zero
         wire           ends     = center ? (dir_down & at_floor) |
                                            (~dir_down & period == '0)
                                          : up_top;
         wire [CNT_W-1:0] next_cnt =
            ends                  ? fcp_pkg::CNT_RST :
            (center & up_top & ~dir_down) ? period :
            dir_down              ? CNT_W'(cnt - 1'b1) :
                                    cnt_inc[CNT_W-1:0];
         wire next_dir = center & ~ends & (dir_down | up_top);

         // Start level until compare point, opposite after; full duty holds start
         wire hold_start = (duty >= period) | (cnt < duty);
         wire level      = hold_start ? mode.start_polarity : ~mode.start_polarity;
         wire next_wave  = enabled ? level : mode.start_polarity;

         assign next_mode.chan_clock_select   =
            reg_wr_in.data[fcp_pkg::CMR_SEL_LSB +: fcp_pkg::SEL_W];
         assign next_mode.center_align_select = reg_wr_in.data[fcp_pkg::CMR_ALIGN_BIT];
         assign next_mode.update_target       = reg_wr_in.data[fcp_pkg::CMR_UPD_BIT];
         assign next_mode.start_polarity      =
            enabled ? mode.start_polarity : reg_wr_in.data[fcp_pkg::CMR_POL_BIT];

         wire load_now   = tick & ends & upd_pending;
         wire direct_upd = upd_wr & ~enabled;

         always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               mode        <= fcp_pkg::CHAN_MODE_RST;
               period      <= fcp_pkg::CNT_RST;
               duty        <= fcp_pkg::CNT_RST;
               upd_val     <= fcp_pkg::CNT_RST;
               upd_pending <= 1'b0;
            end else begin
               if (wr_mode & sel) begin
                  mode <= next_mode;
               end
               if ((wr_period & sel & ~enabled) |
                   (direct_upd & ~mode.update_target)) begin
                  period <= wr_word;
               end else if (load_now & ~mode.update_target) begin
                  period <= upd_val;
               end
               if ((wr_duty & sel & ~enabled) |
                   (direct_upd & mode.update_target)) begin
                  duty <= wr_word;
               end else if (load_now & mode.update_target) begin
                  duty <= upd_val;
               end
               if (upd_wr & enabled) begin
                  upd_val <= wr_word;
               end
               upd_pending <= (upd_wr & enabled) | (upd_pending & ~load_now & enabled);
            end
         end

         always_ff @(posedge mclk_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               enabled  <= 1'b0;
               cnt      <= fcp_pkg::CNT_RST;
               dir_down <= 1'b0;
               wave     <= 1'b0;
            end else begin
               wave <= next_wave;
               if (dis_set) begin
                  enabled  <= 1'b0;
                  cnt      <= fcp_pkg::CNT_RST;
                  dir_down <= 1'b0;
               end else if (en_set) begin
                  enabled  <= 1'b1;
                  cnt      <= fcp_pkg::CNT_RST;
                  dir_down <= 1'b0;
               end else if (tick) begin
                  cnt      <= next_cnt;
                  dir_down <= next_dir;
               end
            end
         end

         assign period_end[i]       = tick & ends;
         assign chan_wave_out[i]    = wave;
         assign chan_enabled_out[i] = enabled;
         assign chan_count_out[i]   = cnt;
      end
   endgenerate

   // Event flags: a new event wins over a clearing read in the same cycle
   wire [NUM_CHAN-1:0] next_flags =
      (irq_flags_out & ~{NUM_CHAN{irq_status_rd_in}}) | period_end;
   wire [NUM_CHAN-1:0] next_mask =
      wr_irq_en  ? (irq_mask_out | wr_bits) :
      wr_irq_dis ? (irq_mask_out & ~wr_bits) : irq_mask_out;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         irq_flags_out <= '0;
         irq_mask_out  <= '0;
         irq_out       <= 1'b0;
      end else begin
         irq_flags_out <= next_flags;
         irq_mask_out  <= next_mask;
         irq_out       <= |(next_flags & next_mask);
      end
   end

endmodule

`default_nettype wire

// ### fcp_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module fcp_core_assertions #(
   parameter int NUM_CHAN = fcp_pkg::NUM_CHAN,
   parameter int CNT_W    = fcp_pkg::CNT_W
) (
   input wire logic                           mclk_in,
   input wire logic                           rst_b_in,
   input wire logic                           func_clk_en_in,
   input wire fcp_pkg::fcp_wr_s               reg_wr_in,
   input wire logic                           irq_status_rd_in,
   input wire logic [NUM_CHAN-1:0]            chan_wave_out,
   input wire logic [NUM_CHAN-1:0]            chan_enabled_out,
   input wire logic [NUM_CHAN-1:0]            irq_flags_out,
   input wire logic [NUM_CHAN-1:0]            irq_mask_out,
   input wire logic                           irq_out,
   input wire fcp_pkg::fcp_clockgen_s         clockgen_mode_out,
   input wire logic [NUM_CHAN-1:0][CNT_W-1:0] chan_count_out
);
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_b_in);

   fcp_pkg::fcp_wr_kind_e kind;
   logic [CNT_W-1:0]      c0;
   assign kind = reg_wr_in.kind;
   assign c0   = chan_count_out[0];

   a_reset_state: assert property ($rose(rst_b_in) |-> clockgen_mode_out == '0 &&
      chan_enabled_out == '0 && chan_count_out == '0 && chan_wave_out == '0)
      else $error("state not cleared by reset");
   a_sync_start: assert property (kind == fcp_pkg::WR_CHAN_ENABLE &&
      reg_wr_in.data[3:0] == 4'hF && chan_enabled_out == '0
      |=> chan_enabled_out == '1 && chan_count_out == '0)
      else $error("joint enable did not start channels together");
   a_disable_clear: assert property (kind == fcp_pkg::WR_CHAN_DISABLE && reg_wr_in.data[0]
      |=> !chan_enabled_out[0] && c0 == '0) else $error("disable did not stop channel");
   a_count_step: assert property (chan_enabled_out[0] && $past(chan_enabled_out[0])
      |-> c0 == $past(c0) || c0 == $past(c0) + 1'b1 || c0 == $past(c0) - 1'b1 || c0 == '0)
      else $error("counter jumped");
   a_gate_hold: assert property ((!func_clk_en_in && kind != fcp_pkg::WR_CHAN_ENABLE &&
      kind != fcp_pkg::WR_CHAN_DISABLE)[*2] |=> $stable(chan_count_out))
      else $error("counters moved while clock gated");
   a_idle_level: assert property ((!chan_enabled_out[0] &&
      kind != fcp_pkg::WR_CHAN_MODE)[*2] |=> $stable(chan_wave_out[0]))
      else $error("idle output moved");
   a_irq_level: assert property (irq_out == |(irq_flags_out & irq_mask_out))
      else $error("interrupt line disagrees with flags and mask");
   a_irq_mask_set: assert property (kind == fcp_pkg::WR_IRQ_ENABLE
      |=> (irq_mask_out & $past(reg_wr_in.data[3:0])) == $past(reg_wr_in.data[3:0]))
      else $error("interrupt mask not set");
   a_flag_cause: assert property ($rose(irq_flags_out[0]) |-> $past(chan_enabled_out[0]))
      else $error("flag set by a stopped channel");
   a_read_clear: assert property (irq_status_rd_in && chan_enabled_out == '0
      |=> irq_flags_out == '0) else $error("flags not cleared by read");
endmodule

bind fcp_core fcp_core_assertions #(.NUM_CHAN(NUM_CHAN), .CNT_W(CNT_W)) u_fcp_chk (
   .mclk_in(mclk_in), .rst_b_in(rst_b_in), .func_clk_en_in(func_clk_en_in),
   .reg_wr_in(reg_wr_in), .irq_status_rd_in(irq_status_rd_in), .chan_wave_out(chan_wave_out),
   .chan_enabled_out(chan_enabled_out), .irq_flags_out(irq_flags_out),
   .irq_mask_out(irq_mask_out), .irq_out(irq_out), .clockgen_mode_out(clockgen_mode_out),
   .chan_count_out(chan_count_out));

`default_nettype wire

// ### fcp_load_model.sv
`timescale 1ns/100ps
`default_nettype none

// Loads on the four pins; counting per cycle makes results phase independent
module fcp_load_model (
   input  wire logic        mclk_in,
   input  wire logic        rst_b_in,
   input  wire logic        clr_in,
   input  wire logic [3:0]  wave_in,
   output logic [3:0][15:0] high_cnt_out,
   output logic [3:0][15:0] rise_cnt_out
);
   logic [3:0] prev;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         high_cnt_out <= '0;
         rise_cnt_out <= '0;
         prev <= '0;
      end else begin
         prev <= wave_in;
         for (int c = 0; c < 4; c++) begin
            high_cnt_out[c] <= clr_in ? 16'h0 : high_cnt_out[c] + {15'h0, wave_in[c]};
            rise_cnt_out[c] <= clr_in ? 16'h0 : rise_cnt_out[c] + {15'h0, wave_in[c] & ~prev[c]};
         end
      end
   end
endmodule

`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic                   mclk_in = 1'b0;
   logic                   rst_b_in = 1'b0;
   logic                   clk_en = 1'b1;
   logic                   rd = 1'b0;
   logic                   clr = 1'b0;
   fcp_pkg::fcp_wr_s       wr_s = '0;
   logic [3:0]             wave, ena, flags, mask;
   logic                   irq;
   fcp_pkg::fcp_clockgen_s cg;
   logic [3:0][15:0]       cnt, hi, rise;
   logic [15:0]            cap;
   int                     errors = 0;
   int                     n_checks = 0;

   always #12.5 mclk_in = ~mclk_in;

   fcp_core uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .func_clk_en_in(clk_en),
      .reg_wr_in(wr_s), .irq_status_rd_in(rd), .chan_wave_out(wave), .chan_enabled_out(ena),
      .irq_flags_out(flags), .irq_mask_out(mask), .irq_out(irq), .clockgen_mode_out(cg),
      .chan_count_out(cnt));
   fcp_load_model load (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .clr_in(clr),
      .wave_in(wave), .high_cnt_out(hi), .rise_cnt_out(rise));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   task automatic wr(input fcp_pkg::fcp_wr_kind_e k, input logic [1:0] ch,
                     input logic [31:0] d);
      @(posedge mclk_in);
      wr_s <= '{k, ch, d};
      @(posedge mclk_in);
      wr_s.kind <= fcp_pkg::WR_NONE;
   endtask

   function automatic logic [31:0] md(input logic [3:0] sel, input logic al, pol, upd);
      return {21'h0, upd, pol, al, 4'h0, sel};
   endfunction

   // Polarity goes in last, after period and duty
   task automatic cfg(input logic [1:0] ch, input logic [3:0] sel, input logic al, pol,
                      input logic [31:0] per, dty);
      wr(fcp_pkg::WR_CHAN_MODE, ch, md(sel, al, 1'b0, 1'b0));
      wr(fcp_pkg::WR_CHAN_PERIOD, ch, per);
      wr(fcp_pkg::WR_CHAN_DUTY, ch, dty);
      wr(fcp_pkg::WR_CHAN_MODE, ch, md(sel, al, pol, 1'b0));
   endtask

   task automatic meas(input int n);
      @(posedge mclk_in);
      clr <= 1'b1;
      @(posedge mclk_in);
      clr <= 1'b0;
      cyc(n);
   endtask

   task automatic rd_pulse();
      @(posedge mclk_in);
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1;
   endtask

   initial begin
      int i;
      repeat (12) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      #1;
      chk("mode", cg, 32'h0);
      chk("enabled", ena, 32'h0);
      chk("wave", wave, 32'h0);
      $display("test reset done");
      // Channel 0 relies on reset defaults: clock 0, left aligned, low start
      wr(fcp_pkg::WR_CHAN_PERIOD, 2'h0, 32'hA);
      wr(fcp_pkg::WR_CHAN_DUTY, 2'h0, 32'h3);
      cfg(2'h1, 4'h0, 1'b1, 1'b0, 32'hA, 32'h3);
      cfg(2'h2, 4'h0, 1'b0, 1'b0, 32'hA, 32'hA);
      cfg(2'h3, 4'h0, 1'b0, 1'b1, 32'hA, 32'hA);
      cyc(2);
      chk("idle_pol", wave, 32'h8);
      wr(fcp_pkg::WR_CHAN_ENABLE, 2'h0, 32'hF);
      meas(40);
      chk("high0", hi[0], 32'h1C);
      chk("rise0", rise[0], 32'h4);
      chk("high1", hi[1], 32'h1E);
      chk("rise1", rise[1], 32'h2);
      chk("high2", hi[2], 32'h0);
      chk("high3", hi[3], 32'h28);
      $display("test waveforms done");
      wr(fcp_pkg::WR_CHAN_PERIOD, 2'h0, 32'h4);
      wr(fcp_pkg::WR_CHAN_DUTY, 2'h0, 32'h1);
      wr(fcp_pkg::WR_CHAN_MODE, 2'h0, md(4'h0, 1'b0, 1'b1, 1'b0));
      meas(40);
      chk("locked", hi[0], 32'h1C);
      $display("test locked done");
      wr(fcp_pkg::WR_CHAN_MODE, 2'h0, md(4'h0, 1'b0, 1'b0, 1'b1));
      wr(fcp_pkg::WR_CHAN_UPDATE, 2'h0, 32'h5);
      cyc(12);
      meas(40);
      chk("upd_duty", hi[0], 32'h14);
      wr(fcp_pkg::WR_CHAN_MODE, 2'h0, md(4'h0, 1'b0, 1'b0, 1'b0));
      wr(fcp_pkg::WR_CHAN_UPDATE, 2'h0, 32'h14);
      cyc(24);
      meas(40);
      chk("upd_per", hi[0], 32'h1E);
      chk("upd_rise", rise[0], 32'h2);
      $display("test update done");
      wr(fcp_pkg::WR_IRQ_ENABLE, 2'h0, 32'h1);
      for (i = 0; i < 40 && irq !== 1'b1; i++) cyc(1);
      chk("irq_up", irq, 32'h1);
      if (irq !== 1'b1) results();
      chk("mask", mask, 32'h1);
      // Read away from the period end so a fresh event cannot refill the flag
      for (i = 0; i < 40 && cnt[0] !== 16'h0; i++) cyc(1);
      rd_pulse();
      chk("flag_clr", flags[0], 32'h0);
      chk("irq_dn", irq, 32'h0);
      wr(fcp_pkg::WR_IRQ_DISABLE, 2'h0, 32'h1);
      cyc(1);
      chk("mask_off", mask, 32'h0);
      $display("test interrupt done");
      @(posedge mclk_in);
      clk_en <= 1'b0;
      cyc(3);
      cap = cnt[0];
      wr(fcp_pkg::WR_CLOCKGEN_MODE, 2'h0, 32'h103);
      cyc(8);
      chk("hold", cnt[0], cap);
      chk("cfg_gated", cg, 32'h103);
      @(posedge mclk_in);
      clk_en <= 1'b1;
      cyc(5);
      chk("resume", cnt[0] !== cap, 32'h1);
      $display("test gating done");
      wr(fcp_pkg::WR_CHAN_DISABLE, 2'h0, 32'hF);
      rd_pulse();
      chk("flags", flags, 32'h0);
      cfg(2'h0, 4'hB, 1'b0, 1'b0, 32'h4, 32'h1);
      cfg(2'h1, 4'hC, 1'b0, 1'b0, 32'h4, 32'h1);
      cfg(2'h2, 4'h3, 1'b0, 1'b0, 32'h4, 32'h1);
      cfg(2'h3, 4'hD, 1'b0, 1'b0, 32'h4, 32'h1);
      wr(fcp_pkg::WR_CHAN_ENABLE, 2'h0, 32'hF);
      cyc(40);
      chk("ena", ena, 32'hF);
      meas(96);
      chk("high_a", hi[0], 32'h48);
      chk("rise_a", rise[0], 32'h4);
      chk("high_p8", hi[2], 32'h48);
      chk("rise_p8", rise[2], 32'h3);
      chk("stop_b", cnt[1], 32'h0);
      chk("sel_none", cnt[3], 32'h0);
      $display("test dividers done");
      for (i = 0; i < 11; i++) begin
         wr(fcp_pkg::WR_CHAN_DISABLE, 2'h0, 32'h4);
         wr(fcp_pkg::WR_CHAN_MODE, 2'h2, md(i[3:0], 1'b0, 1'b0, 1'b0));
         wr(fcp_pkg::WR_CHAN_PERIOD, 2'h2, 32'hFFFF);
         wr(fcp_pkg::WR_CHAN_ENABLE, 2'h0, 32'h4);
         cyc(1024);
         chk("rate", cnt[2] + 2 >= (1024 >> i) && cnt[2] <= (1024 >> i) + 2, 32'h1);
      end
      $display("test prescaler done");
      results();
   end
endmodule

`default_nettype wire
